// File: logic/ser_pkg.sv
// shared constants and types for the safety error and crc register group
// assumes a plain register port on one clock with 16-bit data
package ser_pkg;
   // register port geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   // register offsets
   localparam logic [11:0] OFS_POWER_EN = 12'h042;
   localparam logic [11:0] OFS_CLEAR = 12'h080;
   localparam logic [11:0] OFS_MASK = 12'h081;
   localparam logic [11:0] OFS_SUMMARY = 12'h082;
   localparam logic [11:0] OFS_CODE = 12'h083;
   localparam logic [11:0] OFS_CRC_LOW = 12'h084;
   localparam logic [11:0] OFS_CRC_HIGH = 12'h085;
   localparam logic [11:0] OFS_MAP_CTRL = 12'h086;
   localparam logic [11:0] OFS_MAP_DONE = 12'h087;
   localparam logic [11:0] OFS_MAP_LOW = 12'h088;
   localparam logic [11:0] OFS_MAP_HIGH = 12'h089;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h08a;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h08b;
   // field positions and widths
   localparam int CLK_LOSS_EN_BIT = 9;
   localparam int CLEAR_BIT = 0;
   localparam int MAP_CTRL_BIT = 0;
   localparam int N_FAULT = 6;
   localparam int N_EVT = 7;
   localparam int EVT_DONE_BIT = 6;
   // values after reset, and the map control value that enables the walk
   localparam logic [5:0] MASK_RST = 6'h00;
   localparam logic [5:0] CODE_RST = 6'h00;
   localparam logic [6:0] IRQ_RST = 7'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic CLK_LOSS_EN_RST = 1'b1;
   localparam logic MAP_CTRL_RST = 1'b0;
   localparam logic MAP_CTRL_ENABLED = 1'b0;
   // register map checksum
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   // error sources, msb first matches the code register layout
   typedef struct packed {
      logic clk_loss;
      logic neg_bias_fault;
      logic pos_bias_fault;
      logic vref_fault;
      logic over_heat_fault;
      logic crc_fault;
   } ser_fault_t;
   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ser_bus_t;
   // map checksum walker states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ = 3'b010,
      ST_TAKE = 3'b100
   } ser_state_t;
endpackage

// File: logic/ser_safety_regs.sv
// safety error reporting, masking, interface crc capture and register map crc
// assumes fault levels arrive unsynchronised from analog monitors, and that
// the register map answers a read strobe with data in the following cycle
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1 - mask bit 5 hides clock loss
// RULE2 - mask bit 4 hides negative bias fault
// RULE3 - mask bit 3 hides positive bias fault
// RULE4 - mask bit 2 hides reference fault
// RULE5 - mask bit 1 hides overheat fault
// RULE6 - mask bit 0 hides crc; masks reset zero
// RULE7 - summary bit reads one on error
// RULE8 - code register shows each error bit
// RULE9 - crc value low byte, read only
// RULE10 - crc value high byte, next address
// RULE11 - map crc control: zero enables
// RULE12 - completion bit set when map crc finished
// RULE13 - map crc result low byte
// RULE14 - map crc result high byte
// RULE15 - clear bit high clears, blocks reporting
// RULE16 - clock loss detect only when enabled
// RULE17 - summary is or of unmasked errors
// RULE18 - map crc computed, held, then flagged
// RULE19 - polynomial and byte order chosen here
module ser_safety_regs
   import ser_pkg::*;
#(
   parameter int MAP_AW = 10,
   parameter logic [9:0] MAP_LAST = 10'h0ff
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire ser_fault_t i_faults,
   input wire logic [15:0] i_crc_value,
   input wire logic i_crc_valid,
   input wire logic [15:0] i_map_data,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_irq,
   output logic o_clk_loss_detect_en,
   output logic o_map_rd,
   output logic [MAP_AW-1:0] o_map_addr
);

   // one step of the map checksum: a word, high byte first, msb first
   // no final inversion; each walk restarts from the initial value
   function automatic logic [15:0] crc16_word(input logic [15:0] crc, input logic [15:0] data);
      logic [15:0] c;
      c = crc;
      for (int i = 15; i >= 0; i--) begin
         if (c[15] ^ data[i]) begin
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction

   // a register port hit: the strobe beside a matching address
   function automatic logic port_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
         input logic [ADDR_W-1:0] ofs);
      return strobe && (addr == ofs);
   endfunction

   // one byte of a 16-bit value, placed low in a read word
   function automatic logic [DATA_W-1:0] byte_word(input logic [15:0] value, input logic upper);
      logic [DATA_W-1:0] w;
      w = WORD_RST;
      w[7:0] = upper ? value[15:8] : value[7:0];
      return w;
   endfunction

   // register port bundled
   ser_bus_t bus;
   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // two-stage synchroniser for the monitor levels
   // the monitors run free of this clock; only the second stage feeds logic
   ser_fault_t fault_meta_r;
   ser_fault_t fault_sync_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         fault_meta_r <= CODE_RST;
         fault_sync_r <= CODE_RST;
      end else begin
         fault_meta_r <= i_faults;
         fault_sync_r <= fault_meta_r;
      end
   end

   // software state
   logic clear_r, clear_nxt;
   logic [5:0] mask_r, mask_nxt;
   logic clk_loss_en_r, clk_loss_en_nxt;
   logic map_ctrl_r, map_ctrl_nxt;
   logic [6:0] irq_mask_r, irq_mask_nxt;
   // hardware state
   ser_fault_t code_r, code_nxt;
   logic summary_r, summary_nxt;
   logic [15:0] crc_val_r, crc_val_nxt;
   logic [6:0] irq_stat_r, irq_stat_nxt;
   logic irq_r, irq_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   // map walker state
   ser_state_t state_r, state_nxt;
   logic [MAP_AW-1:0] map_addr_r, map_addr_nxt;
   logic map_rd_r, map_rd_nxt;
   logic [15:0] map_crc_r, map_crc_nxt;
   logic [15:0] map_res_r, map_res_nxt;
   logic map_done_r, map_done_nxt;

   // write decodes and the irq status read decode
   logic wr_clear, wr_mask, wr_power, wr_ctrl, wr_irq_mask, rd_irq_stat;
   assign wr_clear = port_hit(bus.wr, bus.addr, OFS_CLEAR);
   assign wr_mask = port_hit(bus.wr, bus.addr, OFS_MASK);
   assign wr_power = port_hit(bus.wr, bus.addr, OFS_POWER_EN);
   assign wr_ctrl = port_hit(bus.wr, bus.addr, OFS_MAP_CTRL);
   assign wr_irq_mask = port_hit(bus.wr, bus.addr, OFS_IRQ_MASK);
   assign rd_irq_stat = port_hit(bus.rd, bus.addr, OFS_IRQ_STATUS);

   // errors that count toward the summary
   ser_fault_t unmasked;
   logic map_start, map_finish;
   logic [6:0] events;

   // software written registers
   always_comb begin
      clear_nxt = clear_r;
      mask_nxt = mask_r;
      clk_loss_en_nxt = clk_loss_en_r;
      map_ctrl_nxt = map_ctrl_r;
      irq_mask_nxt = irq_mask_r;
      if (wr_clear) begin
         clear_nxt = bus.wdata[CLEAR_BIT];
      end
      // RULE6 mask read write
      if (wr_mask) begin
         mask_nxt = bus.wdata[N_FAULT-1:0];
      end
      if (wr_power) begin
         clk_loss_en_nxt = bus.wdata[CLK_LOSS_EN_BIT];
      end
      // RULE11 control bit store
      if (wr_ctrl) begin
         map_ctrl_nxt = bus.wdata[MAP_CTRL_BIT];
      end
      if (wr_irq_mask) begin
         irq_mask_nxt = bus.wdata[N_EVT-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         clear_r <= 1'b0;
         mask_r <= MASK_RST;
         clk_loss_en_r <= CLK_LOSS_EN_RST;
         map_ctrl_r <= MAP_CTRL_RST;
         irq_mask_r <= IRQ_RST;
      end else begin
         clear_r <= clear_nxt;
         mask_r <= mask_nxt;
         clk_loss_en_r <= clk_loss_en_nxt;
         map_ctrl_r <= map_ctrl_nxt;
         irq_mask_r <= irq_mask_nxt;
      end
   end

   // mask gating per source
   always_comb begin
      // RULE1 clock loss mask
      unmasked.clk_loss = code_r.clk_loss & ~mask_r[5];
      // RULE2 negative bias mask
      unmasked.neg_bias_fault = code_r.neg_bias_fault & ~mask_r[4];
      // RULE3 positive bias mask
      unmasked.pos_bias_fault = code_r.pos_bias_fault & ~mask_r[3];
      // RULE4 reference fault mask
      unmasked.vref_fault = code_r.vref_fault & ~mask_r[2];
      // RULE5 overheat mask
      unmasked.over_heat_fault = code_r.over_heat_fault & ~mask_r[1];
      // RULE6 crc error mask
      unmasked.crc_fault = code_r.crc_fault & ~mask_r[0];
   end

   // error latching and summary
   always_comb begin
      code_nxt = code_r;
      // sticky: a short glitch stays visible until software clears it
      // RULE8 latch each source
      code_nxt = code_r | fault_sync_r;
      // RULE16 detect gated by enable
      code_nxt.clk_loss = (code_r.clk_loss | fault_sync_r.clk_loss) & clk_loss_en_r;
      // RULE15 clear holds errors off
      if (clear_r) begin
         code_nxt = CODE_RST;
      end
      // RULE7 summary flag
      // RULE17 or of unmasked
      summary_nxt = (|unmasked) & ~clear_r; // lags the code register by one cycle
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         code_r <= CODE_RST;
         summary_r <= 1'b0;
      end else begin
         code_r <= code_nxt;
         summary_r <= summary_nxt;
      end
   end

   // interface checksum capture, held until the next valid strobe
   always_comb begin
      crc_val_nxt = crc_val_r;
      // RULE9 capture checksum value
      if (i_crc_valid) begin
         crc_val_nxt = i_crc_value;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         crc_val_r <= WORD_RST;
      end else begin
         crc_val_r <= crc_val_nxt;
      end
   end

   // map walk start and end
   // a start while the walker is busy is ignored, the control bit still stores
   assign map_start = wr_ctrl && (bus.wdata[MAP_CTRL_BIT] == MAP_CTRL_ENABLED);
   assign map_finish = (state_r == ST_TAKE) && (map_addr_r == MAP_LAST[MAP_AW-1:0]);

   // register map checksum walker
   always_comb begin
      state_nxt = state_r;
      map_addr_nxt = map_addr_r;
      map_rd_nxt = 1'b0;
      map_crc_nxt = map_crc_r;
      map_res_nxt = map_res_r;
      map_done_nxt = map_done_r;
      case (state_r)
         ST_IDLE: begin
            // RULE18 start on enable write
            if (map_start) begin
               state_nxt = ST_REQ;
               map_addr_nxt = '0;
               map_rd_nxt = 1'b1;
               map_crc_nxt = CRC_INIT;
               map_done_nxt = 1'b0;
            end
         end
         ST_REQ: begin
            state_nxt = ST_TAKE;
         end
         ST_TAKE: begin
            // RULE19 ccitt word step
            map_crc_nxt = crc16_word(map_crc_r, i_map_data);
            if (map_finish) begin
               state_nxt = ST_IDLE;
               // RULE18 hold result
               map_res_nxt = crc16_word(map_crc_r, i_map_data);
               // RULE12 completion flag
               map_done_nxt = 1'b1;
            end else begin
               state_nxt = ST_REQ;
               map_addr_nxt = map_addr_r + 1'b1;
               map_rd_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // an abort before the last word's take cycle leaves done low and the old result, so no partial sum shows
      // RULE11 one disables and aborts
      if (map_ctrl_r != MAP_CTRL_ENABLED && state_r != ST_IDLE) begin
         state_nxt = ST_IDLE;
         map_rd_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= ST_IDLE;
         map_addr_r <= '0;
         map_rd_r <= 1'b0;
         map_crc_r <= CRC_INIT;
         map_res_r <= WORD_RST;
         map_done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         map_addr_r <= map_addr_nxt;
         map_rd_r <= map_rd_nxt;
         map_crc_r <= map_crc_nxt;
         map_res_r <= map_res_nxt;
         map_done_r <= map_done_nxt;
      end
   end

   // sticky events, read clears, a new event wins over the clear
   // only rising edges count, so a fault held high raises one event
   assign events = {map_done_nxt & ~map_done_r, code_nxt & ~code_r};
   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (rd_irq_stat) begin
         irq_stat_nxt = IRQ_RST;
      end
      irq_stat_nxt = irq_stat_nxt | events;
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_stat_r <= IRQ_RST;
         irq_r <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_r <= irq_nxt;
      end
   end

   // read data, valid only in the cycle after the strobe
   // unused bits and unmapped addresses read as zero
   always_comb begin
      rdata_nxt = WORD_RST;
      if (bus.rd) begin
         case (bus.addr)
            OFS_POWER_EN: rdata_nxt[CLK_LOSS_EN_BIT] = clk_loss_en_r;
            OFS_CLEAR: rdata_nxt[CLEAR_BIT] = clear_r;
            OFS_MASK: rdata_nxt[N_FAULT-1:0] = mask_r;
            // RULE7 summary readback
            OFS_SUMMARY: rdata_nxt[0] = summary_r;
            // RULE8 code readback
            OFS_CODE: rdata_nxt[N_FAULT-1:0] = code_r;
            // RULE9 low byte
            OFS_CRC_LOW: rdata_nxt = byte_word(crc_val_r, 1'b0);
            // RULE10 high byte
            OFS_CRC_HIGH: rdata_nxt = byte_word(crc_val_r, 1'b1);
            OFS_MAP_CTRL: rdata_nxt[MAP_CTRL_BIT] = map_ctrl_r;
            // RULE12 completion readback
            OFS_MAP_DONE: rdata_nxt[0] = map_done_r;
            // RULE13 result low byte
            OFS_MAP_LOW: rdata_nxt = byte_word(map_res_r, 1'b0);
            // RULE14 result high byte
            OFS_MAP_HIGH: rdata_nxt = byte_word(map_res_r, 1'b1);
            OFS_IRQ_STATUS: rdata_nxt[N_EVT-1:0] = irq_stat_r;
            OFS_IRQ_MASK: rdata_nxt[N_EVT-1:0] = irq_mask_r;
            default: rdata_nxt = WORD_RST;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= WORD_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // outputs straight from flops
   assign o_rdata = rdata_r;
   assign o_irq = irq_r;
   assign o_clk_loss_detect_en = clk_loss_en_r;
   assign o_map_rd = map_rd_r;
   assign o_map_addr = map_addr_r;

endmodule
`default_nettype wire

// File: tb/ser_safety_regs_chk.sv
// concurrent checks on the safety register block ports
// bound to every ser_safety_regs instance, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ser_safety_regs_chk
   import ser_pkg::*;
#(
   parameter int MAP_AW = 10,
   parameter logic [9:0] MAP_LAST = 10'h0ff
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic o_irq,
   input wire logic o_clk_loss_detect_en,
   input wire logic o_map_rd,
   input wire logic [MAP_AW-1:0] o_map_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // register port answers
   chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside answer cycle");
   chk_mask_rw: assert property (i_wr && i_addr == OFS_MASK ##1 !(i_wr && i_addr == OFS_MASK) ##1
      i_rd && i_addr == OFS_MASK |=> o_rdata == ($past(i_wdata, 3) & 16'h003f))
      else $error("mask read back wrong");
   chk_unmapped_rd: assert property (i_rd && i_addr == 12'h0ff |=> o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   // clock loss detect enable
   chk_pwr_on: assert property (i_wr && i_addr == OFS_POWER_EN && i_wdata[9] |=> o_clk_loss_detect_en)
      else $error("detect enable not set");
   chk_pwr_off: assert property (i_wr && i_addr == OFS_POWER_EN && !i_wdata[9] |=> !o_clk_loss_detect_en)
      else $error("detect enable not cleared");
   chk_pwr_hold: assert property (!(i_wr && i_addr == OFS_POWER_EN) |=> $stable(o_clk_loss_detect_en))
      else $error("detect enable moved");
   // map walker strobes
   chk_map_single: assert property (o_map_rd |=> !o_map_rd)
      else $error("map strobe longer than one cycle");
   chk_map_step: assert property (o_map_rd ##2 o_map_rd |-> o_map_addr == $past(o_map_addr, 2) + 10'h001)
      else $error("map address not ascending");
   chk_map_bound: assert property (o_map_rd |-> o_map_addr <= MAP_LAST)
      else $error("map address past last word");
   // interrupt masking
   chk_irq_off: assert property (i_wr && i_addr == OFS_IRQ_MASK && i_wdata[6:0] == 7'h00 |=> !o_irq)
      else $error("interrupt with all masked");
   cover property (o_map_rd ##2 o_map_rd);
   cover property (o_irq);
   cover property (i_rd && i_addr == OFS_CODE);
endmodule
bind ser_safety_regs ser_safety_regs_chk #(.MAP_AW(MAP_AW), .MAP_LAST(MAP_LAST)) chk_u (.i_clk(i_clk),
   .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_irq(o_irq), .o_clk_loss_detect_en(o_clk_loss_detect_en), .o_map_rd(o_map_rd), .o_map_addr(o_map_addr));
`default_nettype wire

// File: tb/ser_safety_regs_test.sv
// self-checking bench for the safety error and crc register group
// drives the register port and fault levels, answers map reads itself
`timescale 1ns/100ps
`default_nettype none
module ser_safety_regs_test
   import ser_pkg::*;
;
   localparam logic [9:0] LAST = 10'h003;
   logic i_clk, i_resetn, i_wr, i_rd, i_crc_valid, o_irq, o_clk_loss_detect_en, o_map_rd;
   logic [11:0] i_addr;
   logic [15:0] i_wdata, i_crc_value, i_map_data, o_rdata;
   logic [9:0] o_map_addr;
   ser_fault_t i_faults;
   int failures, cmp_count, cycles;
   ser_safety_regs #(.MAP_LAST(LAST)) dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_faults(i_faults), .i_crc_value(i_crc_value),
      .i_crc_valid(i_crc_valid), .i_map_data(i_map_data), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_clk_loss_detect_en(o_clk_loss_detect_en), .o_map_rd(o_map_rd), .o_map_addr(o_map_addr));
   // map word contents seen by the walker
   function automatic logic [15:0] word(input logic [9:0] a);
      return {6'h00, a} * 16'h0f0f + 16'h1357;
   endfunction
   // reference checksum, one word msb first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
      logic [15:0] r;
      r = c;
      for (int k = 15; k >= 0; k--) r = {r[14:0], 1'b0} ^ ((r[15] ^ w[k]) ? 16'h1021 : 16'h0000);
      return r;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle strobes, a free cycle after each
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_clk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      check(v, exp);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      logic [11:0] a [10];
      a = '{OFS_MASK, OFS_SUMMARY, OFS_CODE, OFS_CRC_LOW, OFS_CRC_HIGH, OFS_MAP_CTRL, OFS_MAP_DONE,
         OFS_MAP_LOW, OFS_MAP_HIGH, OFS_POWER_EN};
      check({15'h0, o_clk_loss_detect_en}, 16'h0001);
      for (int i = 0; i < 10; i++) rdc(a[i], (a[i] == OFS_POWER_EN) ? 16'h0200 : 16'h0000);
   endtask
   task automatic t_regs;
      wr(OFS_MASK, 16'hffff);
      rdc(OFS_MASK, 16'h003f);
      wr(OFS_CODE, 16'h003f);
      rdc(OFS_CODE, 16'h0000);
      wr(12'h0ff, 16'hffff);
      rdc(12'h0ff, 16'h0000);
      rdc(OFS_MASK, 16'h003f);
      wr(OFS_MASK, 16'h0000);
   endtask
   task automatic t_faults;
      wr(OFS_IRQ_MASK, 16'h007f);
      for (int i = 0; i < N_FAULT; i++) begin
         wr(OFS_MASK, 16'h0001 << i);
         i_faults <= ser_fault_t'(6'h01 << i);
         repeat (5) @(posedge i_clk);
         rdc(OFS_CODE, 16'h0001 << i);
         rdc(OFS_SUMMARY, 16'h0000);
         check({15'h0, o_irq}, 16'h0001);
         rdc(OFS_IRQ_STATUS, 16'h0001 << i);
         wr(OFS_MASK, 16'h0000);
         rdc(OFS_SUMMARY, 16'h0001);
         check({15'h0, o_irq}, 16'h0000);
         // clear while the fault still stands: nothing may be reported
         wr(OFS_CLEAR, 16'h0001);
         rdc(OFS_CODE, 16'h0000);
         rdc(OFS_SUMMARY, 16'h0000);
         rdc(OFS_CLEAR, 16'h0001);
         i_faults <= '0;
         repeat (3) @(posedge i_clk);
         wr(OFS_CLEAR, 16'h0000);
         rdc(OFS_CODE, 16'h0000);
      end
      wr(OFS_IRQ_MASK, 16'h0000);
   endtask
   task automatic t_clk_gate;
      wr(OFS_POWER_EN, 16'h0000);
      check({15'h0, o_clk_loss_detect_en}, 16'h0000);
      i_faults <= ser_fault_t'(6'h20);
      repeat (5) @(posedge i_clk);
      rdc(OFS_CODE, 16'h0000);
      rdc(OFS_POWER_EN, 16'h0000);
      i_faults <= '0;
      repeat (4) @(posedge i_clk);
      wr(OFS_POWER_EN, 16'h0200);
   endtask
   task automatic t_crc_value;
      i_crc_value <= 16'ha5c3;
      i_crc_valid <= 1'b1;
      @(posedge i_clk);
      i_crc_valid <= 1'b0;
      i_crc_value <= 16'h0000;
      @(posedge i_clk);
      rdc(OFS_CRC_LOW, 16'h00c3);
      rdc(OFS_CRC_HIGH, 16'h00a5);
   endtask
   task automatic t_map;
      logic [15:0] c, v;
      int n;
      c = CRC_INIT;
      for (int a = 0; a <= LAST; a++) c = crc_step(c, word(a[9:0]));
      wr(OFS_IRQ_MASK, 16'h0040);
      wr(OFS_MAP_CTRL, 16'h0000);
      n = 0;
      v = 16'h0000;
      while (v !== 16'h0001 && n < 40) begin
         rd(OFS_MAP_DONE, v);
         n++;
      end
      check(v, 16'h0001);
      check({15'h0, o_irq}, 16'h0001);
      rdc(OFS_MAP_LOW, {8'h00, c[7:0]});
      rdc(OFS_MAP_HIGH, {8'h00, c[15:8]});
      rdc(OFS_IRQ_STATUS, 16'h0040);
      rdc(OFS_MAP_CTRL, 16'h0000);
      wr(OFS_MAP_CTRL, 16'h0000);
      wr(OFS_MAP_CTRL, 16'h0001);
      rdc(OFS_MAP_CTRL, 16'h0001);
      repeat (20) @(posedge i_clk);
      rdc(OFS_MAP_DONE, 16'h0000);
      rdc(OFS_MAP_LOW, {8'h00, c[7:0]});
      wr(OFS_IRQ_MASK, 16'h0000);
   endtask
   // map data valid the cycle after a strobe, scrambled otherwise
   always @(posedge i_clk) begin
      if (o_map_rd === 1'b1) i_map_data <= word(o_map_addr);
      else i_map_data <= ~word(o_map_addr);
   end
   // cycle ceiling against hangs
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // main sequence
   initial begin
      i_resetn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 12'h000;
      i_wdata = 16'h0000;
      i_faults = '0;
      i_crc_value = 16'h0000;
      i_crc_valid = 1'b0;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      t_reset();
      t_regs();
      t_faults();
      t_clk_gate();
      t_crc_value();
      t_map();
      final_report();
   end
endmodule
`default_nettype wire
